// ### logic/bbsd_defs.vh
// register map, opcode patterns and field positions of the bit/branch decoder
`ifndef BBSD_DEFS_VH
`define BBSD_DEFS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define BBSD_A_CTRL     8'h00
`define BBSD_A_STAT     8'h04
`define BBSD_A_INSTR    8'h08
`define BBSD_A_EXT      8'h0c
`define BBSD_A_PC       8'h10
`define BBSD_A_SR       8'h14
`define BBSD_A_SP       8'h18
`define BBSD_A_OPND     8'h1c
`define BBSD_A_ACC_EXT  8'h20
`define BBSD_A_ACC_HI   8'h24
`define BBSD_A_ACC_LO   8'h28
`define BBSD_A_SSH      8'h2c
`define BBSD_A_SSL      8'h30
`define BBSD_A_AREG_HI  3'h2

// ----------------------------------------------------------------------------
// reset values, bus answers, status bits
// ----------------------------------------------------------------------------
`define BBSD_PC_RST     24'h000000
`define BBSD_SR_RST     16'h0000
`define BBSD_SP_RST     4'h0
`define BBSD_RESP_OKAY  2'h0
`define BBSD_RESP_SLV   2'h2
`define BBSD_ST_BUSY    0
`define BBSD_ST_DONE    1
`define BBSD_ST_TAKEN   2
`define BBSD_ST_ILL     3
`define BBSD_ST_CARRY   4

// ----------------------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------------------
`define BBSD_BSC_LONG   20'h0d040
`define BBSD_UP_SHORT   8'h05
`define BBSD_UP_SUBR    8'h0d
`define BBSD_UP_HIGH    8'h0c
`define BBSD_UP_LOWQ    8'h04
`define BBSD_UP_BIT_FORCE_AND_TEST    8'h0a
`define BBSD_UP_BSETQ   8'h01
`define BBSD_BSC_REGPAT 5'h03

// ----------------------------------------------------------------------------
// addressing, register codes, status word bits
// ----------------------------------------------------------------------------
`define BBSD_PP_BASE    18'h3ffff
`define BBSD_QQ_BASE    18'h3fffe
`define BBSD_EA_PDEC    3'h2
`define BBSD_EA_PINC    3'h3
`define BBSD_EA_NONE    3'h4
`define BBSD_EA_ABS     3'h6
`define BBSD_EA_PREDEC  3'h7
`define BBSD_RC_A0      6'h08
`define BBSD_RC_A2      6'h0a
`define BBSD_RC_A1      6'h0c
`define BBSD_RC_A       6'h0e
`define BBSD_RC_B       6'h0f
`define BBSD_RC_AREG    3'h2
`define BBSD_RC_SR      6'h39
`define BBSD_RC_SSH     6'h3c
`define BBSD_BIT_MAX    5'd23
`define BBSD_SR_C       0
`define BBSD_SR_V       1
`define BBSD_SR_Z       2
`define BBSD_SR_N       3
`define BBSD_SR_U       4
`define BBSD_SR_E       5
`define BBSD_SR_L       6
`define BBSD_SR_S0      10
`define BBSD_SR_S1      11
`define BBSD_POS_LIM    24'h7fffff
`define BBSD_NEG_LIM    24'h800000

`endif

// ### logic/bbsd_core.v
// bit-test branch, conditional subroutine branch and bit force-and-test unit
// Contract
// - condition true: push next address and status word, jump to pc plus displacement
// - condition false: pc plus one, no push, continue sequentially
// - long displacement is signed 24-bit, taken from the extension word
// - short form sign-extends its 9-bit immediate displacement
// - register form adds one of eight address registers to pc
// - conditional subroutine branch opcodes and 4-bit condition field
// - bit low: push next address and status word, jump relative
// - bit high: pc plus one, no push
// - address register update happens whether or not branch is taken
// - stack high word source pops one; taken push reuses that level
// - tested bit number 0 to 23 from instruction low bits; force-and-test here takes only bits 3:0, so bit 0 to 15
// - sources: memory modes, absolute 0-63, two i/o windows, register
// - subroutine-branch-if-bit-low opcode layouts, each with displacement word
// - force-and-test copies bit to carry, sets it, writes back
// - memory force-and-test is a locked read then write
// - full accumulators refused as force-and-test destination; portions allowed
// - accumulator source scaled by scaling bits, limited value sets limit flag
// - status destination: selected condition flag 0-7 set, others kept
// - status destination: selected mode flag 8-15 set, others kept
// - other destinations: carry gets old bit, limit and scaling normal
// - other destinations leave mode flags unchanged
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bbsd_defs.vh"

module bbsd_core (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         dmem_req_r,
	output reg         dmem_we_r,
	output reg         dmem_space_r,
	output reg  [23:0] dmem_addr_r,
	output reg  [23:0] dmem_wdata_r,
	input  wire [23:0] dmem_rdata,
	input  wire        dmem_ack,
	output reg         dmem_lock_r
);

	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_DEC  = 5'b00010;
	localparam [4:0] ST_RD   = 5'b00100;
	localparam [4:0] ST_WR   = 5'b01000;
	localparam [4:0] ST_EXE  = 5'b10000;
	localparam [2:0] F_EA  = 3'h0;
	localparam [2:0] F_AA  = 3'h1;
	localparam [2:0] F_PP  = 3'h2;
	localparam [2:0] F_QQ  = 3'h3;
	localparam [2:0] F_REG = 3'h4;

	reg  [4:0]  st_r;
	reg  [23:0] instr_r;
	reg  [23:0] ext_r;
	reg  [23:0] pc_r;
	reg  [15:0] sr_r;
	reg  [3:0]  sp_r;
	reg  [23:0] opnd_r;
	reg  [7:0]  acc_ext_r;
	reg  [23:0] acc_hi_r;
	reg  [23:0] acc_lo_r;
	reg  [23:0] areg_r [0:7];
	reg  [23:0] stk_hi_r [0:15];
	reg  [15:0] stk_lo_r [0:15];
	reg  [23:0] val_r;
	reg         lim_r;
	reg         done_r;
	reg         taken_r;
	reg         ill_r;
	reg  [7:0]  awaddr_r;
	reg  [31:0] wdata_r;
	reg  [3:0]  wstrb_r;
	integer     k;

	wire        busy  = ~st_r[0];
	wire [7:0]  up    = instr_r[23:16];
	wire        wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	function [31:0] bmerge(input [31:0] o, input [31:0] n, input [3:0] s);
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1)
				bmerge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
		end
	endfunction

	// condition evaluation, upper half is the inverse of the lower
	function cond_true(input [3:0] cc, input [15:0] sr);
		reg b;
		begin
			b = 1'b0;
			case (cc[2:0])
				3'h0: b = ~sr[`BBSD_SR_C];
				3'h1: b = ~(sr[`BBSD_SR_N] ^ sr[`BBSD_SR_V]);
				3'h2: b = ~sr[`BBSD_SR_Z];
				3'h3: b = ~sr[`BBSD_SR_N];
				3'h4: b = ~(sr[`BBSD_SR_Z] | (~sr[`BBSD_SR_U] & ~sr[`BBSD_SR_E]));
				3'h5: b = ~sr[`BBSD_SR_E];
				3'h6: b = ~sr[`BBSD_SR_L];
				default: b = ~(sr[`BBSD_SR_Z] | (sr[`BBSD_SR_N] ^ sr[`BBSD_SR_V]));
			endcase
			cond_true = cc[3] ? ~b : b;
		end
	endfunction

	// bit 32 flags a mapped offset
	function [32:0] reg_rd(input [7:0] a);
		begin
			reg_rd = {1'b1, 32'h00000000};
			case (a)
				`BBSD_A_CTRL:    reg_rd[31:0] = 32'h00000000;
				`BBSD_A_STAT:    reg_rd[4:0] = {sr_r[`BBSD_SR_C], ill_r, taken_r, done_r, busy};
				`BBSD_A_INSTR:   reg_rd[23:0] = instr_r;
				`BBSD_A_EXT:     reg_rd[23:0] = ext_r;
				`BBSD_A_PC:      reg_rd[23:0] = pc_r;
				`BBSD_A_SR:      reg_rd[15:0] = sr_r;
				`BBSD_A_SP:      reg_rd[3:0] = sp_r;
				`BBSD_A_OPND:    reg_rd[23:0] = opnd_r;
				`BBSD_A_ACC_EXT: reg_rd[7:0] = acc_ext_r;
				`BBSD_A_ACC_HI:  reg_rd[23:0] = acc_hi_r;
				`BBSD_A_ACC_LO:  reg_rd[23:0] = acc_lo_r;
				`BBSD_A_SSH:     reg_rd[23:0] = stk_hi_r[sp_r];
				`BBSD_A_SSL:     reg_rd[15:0] = stk_lo_r[sp_r];
				default: begin
					if (a[7:5] == `BBSD_A_AREG_HI)
						reg_rd[23:0] = areg_r[a[4:2]];
					else
						reg_rd[32] = 1'b0;
				end
			endcase
		end
	endfunction

	// ------------------------------------------------------------------------
	// instruction decode
	// ------------------------------------------------------------------------
	reg         is_bsc;
	reg         is_bb;
	reg         is_bit_force_and_test;
	reg         subr;
	reg         ill;
	reg  [2:0]  form;
	reg  [4:0]  bnum;
	reg  [23:0] disp;
	reg  [23:0] maddr;
	reg         ea_upd;
	reg  [23:0] ea_new;
	reg  [23:0] rn;
	reg         bsc_short;
	reg         bsc_reg;
	wire [5:0]  rcode = instr_r[13:8];
	wire [2:0]  mmm   = instr_r[13:11];

	always @* begin
		bsc_short = (up == `BBSD_UP_SHORT) && (instr_r[11:10] == 2'b00) && ~instr_r[5];
		bsc_reg   = (up == `BBSD_UP_SUBR) && (instr_r[15:11] == `BBSD_BSC_REGPAT) &&
			(instr_r[7:4] == 4'h0);
		is_bsc    = (instr_r[23:4] == `BBSD_BSC_LONG) || bsc_short || bsc_reg;
		is_bb     = 1'b0;
		is_bit_force_and_test   = 1'b0;
		ill       = 1'b0;
		form      = F_EA;
		if (!is_bsc && instr_r[15] &&
			((up == `BBSD_UP_SUBR && !instr_r[5]) || (up == `BBSD_UP_HIGH && instr_r[5]))) begin
			is_bb = 1'b1;
			case ({instr_r[14], instr_r[7]})
				2'b00: form = F_EA;
				2'b01: form = F_AA;
				2'b10: form = F_PP;
				default: begin
					form = F_REG;
					ill  = instr_r[6];
				end
			endcase
		end else if (up == `BBSD_UP_LOWQ && instr_r[15:14] == 2'b10 &&
			(instr_r[7] != instr_r[5])) begin
			is_bb = 1'b1;
			form  = F_QQ;
		end else if (up == `BBSD_UP_BIT_FORCE_AND_TEST && !instr_r[7] && instr_r[5:4] == 2'b10) begin
			is_bit_force_and_test = 1'b1;
			case (instr_r[15:14])
				2'b01: form = F_EA;
				2'b00: form = F_AA;
				2'b10: form = F_PP;
				default: begin
					form = F_REG;
					ill  = ~instr_r[6];
				end
			endcase
		end else if (up == `BBSD_UP_BSETQ && instr_r[15:14] == 2'b00 && !instr_r[7] &&
			instr_r[5:4] == 2'b10) begin
			is_bit_force_and_test = 1'b1;
			form    = F_QQ;
		end
		subr = is_bsc | (is_bb & ~instr_r[5]);
		bnum = is_bit_force_and_test ? {1'b0, instr_r[3:0]} : instr_r[4:0];
		if (bsc_short)
			disp = {{15{instr_r[9]}}, instr_r[9:6], instr_r[4:0]};
		else if (bsc_reg)
			disp = areg_r[instr_r[10:8]];
		else
			disp = ext_r;
		rn     = areg_r[instr_r[10:8]];
		ea_upd = 1'b0;
		ea_new = rn;
		maddr  = rn;
		if (is_bb | is_bit_force_and_test)
		case (form)
			F_AA: maddr = {18'h00000, instr_r[13:8]};
			F_PP: maddr = {`BBSD_PP_BASE, instr_r[13:8]};
			F_QQ: maddr = {`BBSD_QQ_BASE, instr_r[13:8]};
			F_EA: begin
				case (mmm)
					`BBSD_EA_NONE: ea_upd = 1'b0;
					`BBSD_EA_PINC: begin
						ea_upd = 1'b1;
						ea_new = rn + 24'h000001;
					end
					`BBSD_EA_PDEC: begin
						ea_upd = 1'b1;
						ea_new = rn - 24'h000001;
					end
					`BBSD_EA_PREDEC: begin
						ea_upd = 1'b1;
						ea_new = rn - 24'h000001;
						maddr  = rn - 24'h000001;
					end
					`BBSD_EA_ABS: begin
						maddr = ext_r;
						ill   = ill | ~is_bit_force_and_test;
					end
					default: ill = 1'b1;
				endcase
			end
			default: maddr = rn;
		endcase
		if (is_bit_force_and_test && form == F_REG && (rcode == `BBSD_RC_A || rcode == `BBSD_RC_B))
			ill = 1'b1;
		if (!is_bsc && bnum > `BBSD_BIT_MAX)
			ill = 1'b1;
		if (!(is_bsc | is_bb | is_bit_force_and_test))
			ill = 1'b1;
	end

	// ------------------------------------------------------------------------
	// register-direct source
	// ------------------------------------------------------------------------
	wire [55:0] acc = {acc_ext_r, acc_hi_r, acc_lo_r};
	reg  [55:0] acc_sh;
	reg         acc_use;
	reg  [23:0] rsrc;

	always @* begin
		case ({sr_r[`BBSD_SR_S1], sr_r[`BBSD_SR_S0]})
			2'b01:   acc_sh = {acc[55], acc[55:1]};
			2'b10:   acc_sh = {acc[54:0], 1'b0};
			default: acc_sh = acc;
		endcase
		acc_use = ~(&acc_sh[55:47] | ~|acc_sh[55:47]);
		case (rcode)
			`BBSD_RC_A0:  rsrc = acc_lo_r;
			`BBSD_RC_A1:  rsrc = acc_hi_r;
			`BBSD_RC_A2:  rsrc = {{16{acc_ext_r[7]}}, acc_ext_r};
			`BBSD_RC_A:   rsrc = acc_use ? (acc_sh[55] ? `BBSD_NEG_LIM : `BBSD_POS_LIM) :
				acc_sh[47:24];
			`BBSD_RC_SR:  rsrc = {8'h00, sr_r};
			`BBSD_RC_SSH: rsrc = stk_hi_r[sp_r];
			default:      rsrc = (rcode[5:3] == `BBSD_RC_AREG) ? areg_r[rcode[2:0]] : opnd_r;
		endcase
	end

	wire [32:0] rd_hit = reg_rd(s_axi_araddr);
	wire [32:0] wr_hit = reg_rd(awaddr_r);
	wire [31:0] wv     = bmerge(wr_hit[31:0], wdata_r, wstrb_r);
	wire        tbit   = val_r[bnum];
	wire [23:0] setv   = val_r | (24'h000001 << bnum);
	wire        take   = is_bsc ? cond_true(bsc_short ? instr_r[15:12] : instr_r[3:0], sr_r) :
		(tbit == instr_r[5]);
	wire [3:0]  sp_inc = sp_r + 4'h1;

	// ------------------------------------------------------------------------
	// bus slave, registers and sequencer
	// ------------------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `BBSD_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `BBSD_RESP_OKAY;
			s_axi_rdata   <= 32'h00000000;
			awaddr_r      <= 8'h00;
			wdata_r       <= 32'h00000000;
			wstrb_r       <= 4'h0;
			dmem_req_r    <= 1'b0;
			dmem_we_r     <= 1'b0;
			dmem_space_r  <= 1'b0;
			dmem_addr_r   <= 24'h000000;
			dmem_wdata_r  <= 24'h000000;
			dmem_lock_r   <= 1'b0;
			st_r          <= ST_IDLE;
			instr_r       <= 24'h000000;
			ext_r         <= 24'h000000;
			pc_r          <= `BBSD_PC_RST;
			sr_r          <= `BBSD_SR_RST;
			sp_r          <= `BBSD_SP_RST;
			opnd_r        <= 24'h000000;
			acc_ext_r     <= 8'h00;
			acc_hi_r      <= 24'h000000;
			acc_lo_r      <= 24'h000000;
			val_r         <= 24'h000000;
			lim_r         <= 1'b0;
			done_r        <= 1'b0;
			taken_r       <= 1'b0;
			ill_r         <= 1'b0;
			for (k = 0; k < 8; k = k + 1)
				areg_r[k] <= 24'h000000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_r      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r      <= s_axi_wdata;
				wstrb_r      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rdata   <= rd_hit[31:0];
				s_axi_rresp   <= rd_hit[32] ? `BBSD_RESP_OKAY : `BBSD_RESP_SLV;
				s_axi_rvalid  <= 1'b1;
				s_axi_arready <= 1'b0;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
			// writes refused while an instruction runs
			if (wr_go) begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
				s_axi_bvalid  <= 1'b1;
				s_axi_bresp   <= (wr_hit[32] && !busy) ? `BBSD_RESP_OKAY : `BBSD_RESP_SLV;
				if (wr_hit[32] && !busy) begin
					case (awaddr_r)
						`BBSD_A_CTRL: begin
							if (wv[0]) begin
								st_r    <= ST_DEC;
								done_r  <= 1'b0;
								taken_r <= 1'b0;
								ill_r   <= 1'b0;
							end
						end
						`BBSD_A_INSTR:   instr_r <= wv[23:0];
						`BBSD_A_EXT:     ext_r <= wv[23:0];
						`BBSD_A_PC:      pc_r <= wv[23:0];
						`BBSD_A_SR:      sr_r <= wv[15:0];
						`BBSD_A_SP:      sp_r <= wv[3:0];
						`BBSD_A_OPND:    opnd_r <= wv[23:0];
						`BBSD_A_ACC_EXT: acc_ext_r <= wv[7:0];
						`BBSD_A_ACC_HI:  acc_hi_r <= wv[23:0];
						`BBSD_A_ACC_LO:  acc_lo_r <= wv[23:0];
						default: begin
							if (awaddr_r[7:5] == `BBSD_A_AREG_HI)
								areg_r[awaddr_r[4:2]] <= wv[23:0];
						end
					endcase
				end
			end
			case (st_r)
				// go from the write port must not be overridden here
				ST_IDLE: begin
				end
				ST_DEC: begin
					lim_r <= 1'b0;
					if (ill) begin
						ill_r  <= 1'b1;
						done_r <= 1'b1;
						st_r   <= ST_IDLE;
					end else if (is_bsc) begin
						st_r <= ST_EXE;
					end else if (form == F_REG) begin
						val_r <= rsrc;
						lim_r <= (rcode == `BBSD_RC_A) & acc_use;
						if (is_bb && rcode == `BBSD_RC_SSH)
							sp_r <= sp_r - 4'h1;
						st_r <= ST_EXE;
					end else begin
						// lock held across read and write
						dmem_req_r   <= 1'b1;
						dmem_we_r    <= 1'b0;
						dmem_space_r <= instr_r[6];
						dmem_addr_r  <= maddr;
						dmem_lock_r  <= is_bit_force_and_test;
						if (form == F_EA && ea_upd)
							areg_r[instr_r[10:8]] <= ea_new;
						st_r <= ST_RD;
					end
				end
				ST_RD: begin
					if (dmem_ack) begin
						val_r <= dmem_rdata;
						if (is_bit_force_and_test) begin
							dmem_we_r    <= 1'b1;
							dmem_wdata_r <= dmem_rdata | (24'h000001 << bnum);
							st_r         <= ST_WR;
						end else begin
							dmem_req_r <= 1'b0;
							st_r       <= ST_EXE;
						end
					end
				end
				ST_WR: begin
					if (dmem_ack) begin
						dmem_req_r  <= 1'b0;
						dmem_we_r   <= 1'b0;
						dmem_lock_r <= 1'b0;
						st_r        <= ST_EXE;
					end
				end
				ST_EXE: begin
					done_r <= 1'b1;
					st_r   <= ST_IDLE;
					if (is_bit_force_and_test) begin
						pc_r <= pc_r + 24'h000001;
						if (form == F_REG && rcode == `BBSD_RC_SR) begin
							sr_r <= sr_r | (16'h0001 << bnum[3:0]);
						end else begin
							sr_r[`BBSD_SR_C] <= tbit;
							if (form == F_REG) begin
								case (rcode)
									`BBSD_RC_A0:  acc_lo_r <= setv;
									`BBSD_RC_A1:  acc_hi_r <= setv;
									`BBSD_RC_A2:  acc_ext_r <= setv[7:0];
									`BBSD_RC_SSH: stk_hi_r[sp_r] <= setv;
									default: begin
										if (rcode[5:3] == `BBSD_RC_AREG)
											areg_r[rcode[2:0]] <= setv;
										else
											opnd_r <= setv;
									end
								endcase
							end
						end
					end else begin
						taken_r <= take;
						if (lim_r)
							sr_r[`BBSD_SR_L] <= 1'b1;
						if (take) begin
							pc_r <= pc_r + disp;
							if (subr) begin
								sp_r           <= sp_inc;
								stk_hi_r[sp_inc] <= pc_r + 24'h000001;
								stk_lo_r[sp_inc] <= sr_r;
							end
						end else begin
							pc_r <= pc_r + 24'h000001;
						end
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

endmodule // bbsd_core
`default_nettype wire

// ### tb/bbsd_mem_model.sv
// data memory model: sixteen words, ack after a chosen wait
`timescale 1ns/1ps
`default_nettype none
module bbsd_mem_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic [23:0] addr,
	input  wire logic [23:0] wdata,
	input  wire logic [1:0]  lat,
	output wire logic [23:0] rdata,
	output var  logic        ack
);
	logic [23:0] cells [0:15];
	logic [1:0]  cnt_r;
	// data not yet acked shows the inverse, never a stale word
	assign rdata = ack ? cells[addr[3:0]] : ~cells[addr[3:0]];
	always @(posedge aclk) begin
		if (!aresetn) begin
			ack <= 1'b0;
			cnt_r <= 2'h0;
		end else if (req && !ack && cnt_r != lat) begin
			cnt_r <= cnt_r + 2'h1;
		end else begin
			ack <= req && !ack;
			cnt_r <= 2'h0;
			if (req && !ack && we)
				cells[addr[3:0]] <= wdata;
		end
	end
endmodule // bbsd_mem_model
`default_nettype wire

// ### tb/bbsd_chk_assertions.sv
// checker: bus answers and the locked read-modify-write
`timescale 1ns/1ps
`default_nettype none
module bbsd_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        dmem_req_r,
	input wire logic        dmem_we_r,
	input wire logic [23:0] dmem_addr_r,
	input wire logic [23:0] dmem_wdata_r,
	input wire logic [23:0] dmem_rdata,
	input wire logic        dmem_ack,
	input wire logic        dmem_lock_r
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire rd_ack = dmem_lock_r && dmem_req_r && !dmem_we_r && dmem_ack;
	wr_locked_a: assert property (dmem_req_r && dmem_we_r |-> dmem_lock_r)
		else $error("memory write outside a locked sequence");
	rmw_next_a: assert property (rd_ack |=> dmem_req_r && dmem_we_r && dmem_lock_r)
		else $error("locked read not followed by its write");
	rmw_data_a: assert property (rd_ack |=>
		(dmem_wdata_r & $past(dmem_rdata)) == $past(dmem_rdata) &&
		$countones(dmem_wdata_r ^ $past(dmem_rdata)) <= 1)
		else $error("written word is not the read word with one bit forced");
	req_hold_a: assert property (dmem_req_r && !dmem_ack |=>
		dmem_req_r && $stable(dmem_addr_r) && $stable(dmem_we_r))
		else $error("memory request changed before ack");
	lock_end_a: assert property (dmem_req_r && dmem_we_r && dmem_ack |=>
		!dmem_req_r && !dmem_lock_r)
		else $error("lock not released after the write");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	r_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hfc
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	cover property (rd_ack ##[1:8] dmem_we_r && dmem_ack);
	cover property ((dmem_req_r && !dmem_ack) [*3]);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule // bbsd_chk
bind bbsd_core bbsd_chk u_chk (.*);
`default_nettype wire

// ### tb/tb_top.sv
// testbench: register-level runs of branch and force-and-test instructions
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [1:0]  lat = 2'h0;
	logic [31:0] got;
	logic [1:0]  resp;
	integer      err_total = 0;
	integer      n_checks = 0;
	wire         awready, wready, bvalid, arready, rvalid, req, we, ack, lock;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire [23:0]  addr, mwd, mrd;
	initial forever #4 aclk = ~aclk;
	bbsd_core dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .dmem_req_r(req),
		.dmem_we_r(we), .dmem_space_r(), .dmem_addr_r(addr), .dmem_wdata_r(mwd),
		.dmem_rdata(mrd), .dmem_ack(ack), .dmem_lock_r(lock));
	bbsd_mem_model u_mem (.aclk(aclk), .aresetn(aresetn), .req(req), .we(we),
		.addr(addr), .wdata(mwd), .lat(lat), .rdata(mrd), .ack(ack));
	// ------
	// tasks
	// ------
	task print_verdict;
		begin
			if (err_total == 0 && n_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("Error %0t: got %h exp %h", $time, g, e);
			end
		end
	endtask
	task hang(input integer n);
		begin
			if (n >= 60) begin
				err_total = err_total + 1;
				print_verdict;
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		integer n;
		logic dn;
		begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			n = 0;
			dn = 1'b0;
			while (!dn && n < 60) begin
				@(posedge aclk);
				n = n + 1;
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
				if (bvalid) begin
					resp = bresp;
					dn = 1'b1;
				end
			end
			hang(n);
		end
	endtask
	task rd(input [7:0] a);
		integer n;
		logic dn;
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			n = 0;
			dn = 1'b0;
			while (!dn && n < 60) begin
				@(posedge aclk);
				n = n + 1;
				if (arready) arvalid <= 1'b0;
				if (rvalid) begin
					got = rdata;
					resp = rresp;
					dn = 1'b1;
				end
			end
			hang(n);
		end
	endtask
	task rc(input [7:0] a, input [31:0] e);
		begin
			rd(a);
			chk(got, e);
		end
	endtask
	// instruction word, extension word, go, then poll busy
	task run(input [23:0] i, input [23:0] x);
		integer n;
		begin
			wr(8'h08, {8'h00, i});
			wr(8'h0c, {8'h00, x});
			wr(8'h00, 32'h1);
			n = 0;
			got = 32'h1;
			while (got[0] && n < 60) begin
				rd(8'h04);
				n = n + 1;
			end
			hang(n);
		end
	endtask
	// ------
	// sequence
	// ------
	initial begin
		u_mem.cells[4] = 24'h000020;
		u_mem.cells[5] = 24'h000020;
		u_mem.cells[8] = 24'h000f00;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(8'h10, 32'h0);
		rc(8'h18, 32'h0);
		rd(8'hfc);
		chk(resp, 2'h2);
		wr(8'h14, 32'h300);
		wr(8'h10, 32'h100);
		run(24'h0d0400, 24'hfffff0);
		chk(got, 32'h6);
		rc(8'h10, 32'hf0);
		rc(8'h2c, 32'h101);
		rc(8'h30, 32'h300);
		run(24'h0d0408, 24'h0);
		chk(got, 32'h2);
		rc(8'h10, 32'hf1);
		rc(8'h18, 32'h1);
		run(24'h0503de, 24'h0);
		rc(8'h10, 32'hef);
		rc(8'h2c, 32'hf2);
		wr(8'h4c, 32'h10);
		run(24'h0d1b00, 24'h0);
		rc(8'h10, 32'hff);
		rc(8'h18, 32'h3);
		wr(8'h40, 32'h8);
		run(24'h0dd083, 24'h40);
		rc(8'h10, 32'h100);
		rc(8'h18, 32'h3);
		run(24'h0dd082, 24'h40);
		rc(8'h10, 32'h140);
		rc(8'h2c, 32'h101);
		run(24'h0dd098, 24'h40);
		chk(got[3], 1'b1);
		rc(8'h10, 32'h140);
		wr(8'h44, 32'h4);
		run(24'h0d9905, 24'h40);
		rc(8'h10, 32'h141);
		rc(8'h44, 32'h5);
		lat <= 2'h2;
		run(24'h0c9925, 24'h40);
		rc(8'h10, 32'h181);
		rc(8'h18, 32'h4);
		rc(8'h44, 32'h6);
		wr(8'h48, 32'h8);
		run(24'h0a6227, 24'h0);
		chk(got[4], 1'b0);
		chk(u_mem.cells[8], 24'h000f80);
		run(24'h0a6227, 24'h0);
		chk(got[4], 1'b1);
		rc(8'h14, 32'h301);
		run(24'h0af962, 24'h0);
		rc(8'h14, 32'h305);
		run(24'h0af96c, 24'h0);
		rc(8'h14, 32'h1305);
		run(24'h0ace61, 24'h0);
		chk(got[3], 1'b1);
		run(24'h0acc60, 24'h0);
		rc(8'h24, 32'h1);
		print_verdict;
	end
endmodule // tb_top
`default_nettype wire
